// ===== design/spk_regs.vh
`ifndef SPK_REGS_VH
`define SPK_REGS_VH

// Mode encodings
`define SPK_MODE_TRANSPARENT 1'b0
`define SPK_MODE_FRAMED      1'b1

// Default command-entry figures
`define SPK_GUARD_TIME_MS     16'h03E8
`define SPK_CMD_SEQ_CHAR      8'h2B
`define SPK_CMD_SEQ_COUNT     2'h3
`define SPK_CLK_MHZ           125
// Cycles per millisecond at the reference clock
`define SPK_CYC_PER_MS        (`SPK_CLK_MHZ * 1000)

// Default packet settings
`define SPK_MAX_PAYLOAD       8'h54
`define SPK_TIMEOUT_TICKS     32'h0000_0C35

// Frame delimiters and status codes for framed traffic
`define SPK_FRAME_START       8'h7E
`define SPK_FRAME_RX_TAG      8'h90
`define SPK_STATUS_OK         8'h00
`define SPK_STATUS_FAIL       8'h01

`endif

// ===== design/spk_packetizer.v
// Contract
// - Transparent mode queues serial input bytes only while collecting with room left
// - Transparent mode forwards radio payload unchanged
// - No transparent mode while SPI is active
// - Close packet after idle packetization timeout
// - Zero timeout closes packet on any byte
// - Command sequence flushes bytes buffered before it
// - Close packet when byte count hits maximum
// - Input during command mode is not forwarded
// - Framed mode frames host-bound radio and status traffic; serial input is queued unframed
// - Framed mode answers transmit with status frame
// - Framed radio delivery carries sender address
// - Default sequence: silence, three plus, silence
`timescale 1ns/1ps
`default_nettype none
`include "spk_regs.vh"

module spk_packetizer #(
  parameter DEPTH      = 128,
  parameter AW         = 7,
  parameter GUARD_CYC  = `SPK_GUARD_TIME_MS * `SPK_CYC_PER_MS
) (
  input  wire        i_ref_clk,
  input  wire        i_srst,
  input  wire        i_mode_framed,
  input  wire        i_spi_active,
  input  wire [7:0]  i_max_payload,
  input  wire [31:0] i_packetization_timeout,
  input  wire [7:0]  i_command_sequence_char,
  input  wire        i_cmd_exit,
  input  wire        i_ser_valid,
  input  wire [7:0]  i_ser_data,
  input  wire        i_pkt_ready,
  input  wire        i_rf_valid,
  input  wire [7:0]  i_rf_data,
  input  wire        i_rf_first,
  input  wire [15:0] i_rf_src_addr,
  input  wire        i_tx_done,
  input  wire        i_tx_ok,
  input  wire        i_host_ready,
  output reg         o_pkt_valid,
  output reg  [7:0]  o_pkt_data,
  output reg         o_pkt_last,
  output reg         o_host_valid,
  output reg  [7:0]  o_host_data,
  output reg         o_cmd_mode,
  output reg         o_framed_eff,
  output reg         o_ser_drop
);

  localparam S_COLLECT = 2'b01;
  localparam S_SEND    = 2'b10;

  // Host-bound frame steps
  localparam H_IDLE    = 5'b00001;
  localparam H_TAG     = 5'b00010;
  localparam H_ADDR_HI = 5'b00100;
  localparam H_ADDR_LO = 5'b01000;
  localparam H_STATUS  = 5'b10000;

  // Receive queue
  reg [7:0]    mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [7:0]    count_r;
  reg [7:0]    send_left_r;
  reg [1:0]    state_r;

  // Silence counters
  reg [31:0]   idle_r;
  reg [31:0]   guard_r;

  // Command sequence detector
  reg [1:0]    plus_r;
  reg          pre_ok_r;
  reg [7:0]    plus_mark_r;

  // Host-bound frames
  reg [4:0]    hdr_r;
  reg [15:0]   src_r;
  reg          stat_pend_r;
  reg [7:0]    stat_code_r;

  // Serial intake and packet closing
  wire          framed     = i_mode_framed | i_spi_active;
  wire          collecting = (state_r == S_COLLECT);
  wire          has_room   = (count_r < i_max_payload);
  wire          take       = i_ser_valid & ~o_cmd_mode & collecting & has_room;
  wire          is_plus    = ~framed & (i_ser_data == i_command_sequence_char);
  wire          guard_ok   = (guard_r >= GUARD_CYC);
  wire          seq_done   = (plus_r == `SPK_CMD_SEQ_COUNT) & guard_ok;
  wire          full_hit   = (count_r != 8'h00) & (count_r >= i_max_payload);
  wire          to_zero    = (i_packetization_timeout == 32'h0000_0000);
  wire          to_idle    = (idle_r >= i_packetization_timeout);
  wire          to_hit     = (count_r != 8'h00) & (to_zero | to_idle);
  wire          pkt_go     = o_pkt_valid & i_pkt_ready;
  wire [AW-1:0] seq_len    = count_r[AW-1:0] - plus_mark_r[AW-1:0];
  wire [7:0]    head_byte  = mem_r[rd_ptr_r];

  // Host path handshake
  wire          host_free  = ~o_host_valid | i_host_ready;
  wire          stat_sent  = (hdr_r == H_STATUS) & host_free;

  // One flip-flop row per queue entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
      always @(posedge i_ref_clk) begin
        if (take && (wr_ptr_r == gi)) begin
          mem_r[gi] <= i_ser_data;
        end
      end
    end
  endgenerate

  // Silence counters for the idle timeout and the guard time
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      idle_r  <= 32'h0000_0000;
      guard_r <= 32'h0000_0000;
    end else if (i_ser_valid) begin
      idle_r  <= 32'h0000_0000;
      guard_r <= 32'h0000_0000;
    end else begin
      if (!guard_ok) guard_r <= guard_r + 32'h0000_0001;
      if (idle_r != 32'hFFFF_FFFF) idle_r <= idle_r + 32'h0000_0001;
    end
  end

  // Command sequence detector, transparent mode only
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      plus_r      <= 2'h0;
      pre_ok_r    <= 1'b0;
      plus_mark_r <= 8'h00;
      o_cmd_mode  <= 1'b0;
    end else if (o_cmd_mode) begin
      if (i_cmd_exit | framed) o_cmd_mode <= 1'b0;
      plus_r <= 2'h0;
    end else if (i_ser_valid) begin
      if (is_plus && (plus_r == 2'h0) && guard_ok) begin
        plus_r      <= 2'h1;
        pre_ok_r    <= 1'b1;
        plus_mark_r <= count_r;
      end else if (is_plus && pre_ok_r && (plus_r != `SPK_CMD_SEQ_COUNT)) begin
        plus_r <= plus_r + 2'h1;
      end else begin
        plus_r   <= 2'h0;
        pre_ok_r <= 1'b0;
      end
    end else if (seq_done) begin
      o_cmd_mode <= 1'b1;
      plus_r     <= 2'h0;
      pre_ok_r   <= 1'b0;
    end else if ((plus_r != 2'h0) && guard_ok &&
                 (plus_r != `SPK_CMD_SEQ_COUNT)) begin
      plus_r   <= 2'h0;
      pre_ok_r <= 1'b0;
    end
  end

  // Effective mode and dropped-byte flags
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_framed_eff <= 1'b0;
      o_ser_drop   <= 1'b0;
    end else begin
      o_framed_eff <= framed;
      o_ser_drop   <= i_ser_valid & ~o_cmd_mode & ~take;
    end
  end

  // Queue pointers, packet closing and the packet stream
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      count_r     <= 8'h00;
      send_left_r <= 8'h00;
      state_r     <= S_COLLECT;
      o_pkt_valid <= 1'b0;
      o_pkt_data  <= 8'h00;
      o_pkt_last  <= 1'b0;
    end else begin
      if (take) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end

      case (state_r)
        S_COLLECT: begin
          if (seq_done && !o_cmd_mode) begin
            // Drop the sequence characters, send what came before
            wr_ptr_r <= wr_ptr_r - seq_len;
            count_r  <= plus_mark_r;
            if (plus_mark_r != 8'h00) begin
              send_left_r <= plus_mark_r;
              state_r     <= S_SEND;
            end
          end else if (full_hit || (to_hit && !take && (plus_r == 2'h0))) begin
            send_left_r <= count_r;
            state_r     <= S_SEND;
          end else if (take) begin
            count_r <= count_r + 8'h01;
          end
        end

        S_SEND: begin
          // Output empty or beat accepted: load the next byte
          if (!o_pkt_valid || pkt_go) begin
            if (send_left_r != 8'h00) begin
              o_pkt_valid <= 1'b1;
              o_pkt_data  <= head_byte;
              o_pkt_last  <= (send_left_r == 8'h01);
              rd_ptr_r    <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
              send_left_r <= send_left_r - 8'h01;
            end else begin
              o_pkt_valid <= 1'b0;
              o_pkt_last  <= 1'b0;
              count_r     <= 8'h00;
              state_r     <= S_COLLECT;
            end
          end
        end

        default: begin
          state_r <= S_COLLECT;
        end
      endcase
    end
  end

  // Pending transmit status; a new outcome wins over the clear
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      stat_pend_r <= 1'b0;
      stat_code_r <= 8'h00;
    end else if (i_tx_done && framed) begin
      stat_pend_r <= 1'b1;
      stat_code_r <= i_tx_ok ? `SPK_STATUS_OK : `SPK_STATUS_FAIL;
    end else if (stat_sent) begin
      stat_pend_r <= 1'b0;
    end
  end

  // Host-bound path: raw in transparent mode, framed otherwise
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_host_valid <= 1'b0;
      o_host_data  <= 8'h00;
      hdr_r        <= H_IDLE;
      src_r        <= 16'h0000;
    end else if (host_free) begin
      o_host_valid <= 1'b0;
      case (hdr_r)
        H_TAG: begin
          o_host_valid <= 1'b1;
          o_host_data  <= `SPK_FRAME_RX_TAG;
          hdr_r        <= H_ADDR_HI;
        end

        H_ADDR_HI: begin
          o_host_valid <= 1'b1;
          o_host_data  <= src_r[15:8];
          hdr_r        <= H_ADDR_LO;
        end

        H_ADDR_LO: begin
          o_host_valid <= 1'b1;
          o_host_data  <= src_r[7:0];
          hdr_r        <= H_IDLE;
        end

        H_STATUS: begin
          o_host_valid <= 1'b1;
          o_host_data  <= stat_code_r;
          hdr_r        <= H_IDLE;
        end

        H_IDLE: begin
          if (i_rf_valid && framed && i_rf_first) begin
            o_host_valid <= 1'b1;
            o_host_data  <= `SPK_FRAME_START;
            src_r        <= i_rf_src_addr;
            hdr_r        <= H_TAG;
          end else if (i_rf_valid) begin
            o_host_valid <= 1'b1;
            o_host_data  <= i_rf_data;
          end else if (stat_pend_r && framed) begin
            o_host_valid <= 1'b1;
            o_host_data  <= `SPK_FRAME_START;
            hdr_r        <= H_STATUS;
          end
        end

        default: begin
          hdr_r <= H_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== tb/spk_packetizer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module spk_packetizer_chk (
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic       i_spi_active,
  input wire logic       i_ser_valid,
  input wire logic       i_pkt_ready,
  input wire logic       i_rf_valid,
  input wire logic [7:0] i_rf_data,
  input wire logic       i_host_ready,
  input wire logic [7:0] i_max_payload,
  input wire logic       o_pkt_valid,
  input wire logic [7:0] o_pkt_data,
  input wire logic       o_pkt_last,
  input wire logic       o_host_valid,
  input wire logic [7:0] o_host_data,
  input wire logic       o_cmd_mode,
  input wire logic       o_framed_eff,
  input wire logic       o_ser_drop
);
  logic [7:0] beat_r;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // Beats already sent in the current packet
  always @(posedge i_ref_clk) begin
    if (i_srst) beat_r <= 8'h00;
    else if (o_pkt_valid && i_pkt_ready) beat_r <= o_pkt_last ? 8'h00 : beat_r + 8'h01;
  end
  chk_spi_forces_framed: assert property (i_spi_active |=> o_framed_eff)
    else $error("framed mode not forced by spi");
  chk_pkt_beat_held: assert property (o_pkt_valid && !i_pkt_ready |=> o_pkt_valid && $stable(o_pkt_data))
    else $error("packet beat changed while stalled");
  chk_host_beat_held: assert property (o_host_valid && !i_host_ready |=> o_host_valid && $stable(o_host_data))
    else $error("host beat changed while stalled");
  chk_pkt_size_limit: assert property (o_pkt_valid |-> beat_r < i_max_payload)
    else $error("packet longer than maximum");
  chk_last_only_valid: assert property (o_pkt_last |-> o_pkt_valid)
    else $error("last without valid");
  chk_cmd_no_drop: assert property (o_cmd_mode && i_ser_valid |=> !o_ser_drop)
    else $error("drop flagged in command mode");
  chk_cmd_not_framed: assert property ($rose(o_cmd_mode) |-> !$past(o_framed_eff))
    else $error("command mode entered while framed");
  chk_rf_passthrough: assert property (!o_framed_eff && i_rf_valid && (!o_host_valid || i_host_ready)
    |=> o_host_valid && o_host_data == $past(i_rf_data))
    else $error("radio byte not forwarded");
endmodule
`default_nettype wire

// ===== tb/spk_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spk_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_spi,
  output wire logic       o_ready,
  output wire logic       o_mode_framed
);
  logic [7:0] rx_q[$];
  logic       tog_r = 1'b0;
  // Host runs framed traffic whenever spi carries the link
  assign o_mode_framed = i_spi;
  assign o_ready = tog_r;
  // Accepts on alternate cycles only
  always @(posedge i_clk) begin
    if (i_valid && tog_r) rx_q.push_back(i_data);
    tog_r <= ~tog_r;
  end
endmodule
`default_nettype wire

// ===== tb/spk_packetizer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spk_packetizer_tb;
  logic        clk = 0, srst = 1, ser_v = 0, rf_v = 0, first = 0, done = 0, ok = 0, cx = 0, spi = 0;
  logic [7:0]  ser_d = 0, rf_d = 0, maxp = 8'h08;
  logic [31:0] to = 0;
  logic        pkt_r = 0;
  wire         pkt_v, pkt_l, host_v, host_r, mode_f, cmd_m, fr_eff, drop;
  wire  [7:0]  pkt_d, host_d;
  int          mismatches = 0, cmp_count = 0;
  logic [7:0]  exp_b [0:8] = '{8'h3C, 8'h7E, 8'h90, 8'h12, 8'h34, 8'h7E, 8'h00, 8'h7E, 8'h01};
  spk_packetizer #(.GUARD_CYC(32'd50)) i_dut (.i_ref_clk(clk), .i_srst(srst), .i_mode_framed(mode_f),
    .i_spi_active(spi), .i_max_payload(maxp), .i_packetization_timeout(to),
    .i_command_sequence_char(8'h2B), .i_cmd_exit(cx), .i_ser_valid(ser_v), .i_ser_data(ser_d),
    .i_pkt_ready(pkt_r), .i_rf_valid(rf_v), .i_rf_data(rf_d), .i_rf_first(first),
    .i_rf_src_addr(16'h1234), .i_tx_done(done), .i_tx_ok(ok), .i_host_ready(host_r),
    .o_pkt_valid(pkt_v), .o_pkt_data(pkt_d), .o_pkt_last(pkt_l), .o_host_valid(host_v),
    .o_host_data(host_d), .o_cmd_mode(cmd_m), .o_framed_eff(fr_eff), .o_ser_drop(drop));
  spk_host_model i_host (.i_clk(clk), .i_valid(host_v), .i_data(host_d), .i_spi(spi),
    .o_ready(host_r), .o_mode_framed(mode_f));
  initial forever #4 clk = ~clk;
  // Radio side stalls every other cycle
  always @(posedge clk) pkt_r <= ~pkt_r;
  task automatic stop_test;
    $display("%0d compared, %0d wrong", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    ser_v <= 1'b1;
    ser_d <= b;
    @(posedge clk);
    ser_v <= 1'b0;
  endtask
  task automatic pulse(input int w); // 0 radio byte, 1 tx done, 2 command exit
    @(posedge clk);
    if (w == 0) rf_v <= 1'b1; else if (w == 1) done <= 1'b1; else cx <= 1'b1;
    @(posedge clk);
    {rf_v, done, cx} <= 3'b000;
  endtask
  task automatic await(input int kind, input int n);
    int k;
    k = 0;
    do begin @(negedge clk); k++; end
    while ((kind == 0 ? !(pkt_v === 1'b1 && pkt_r === 1'b1) : i_host.rx_q.size() < n) && k < 300);
    if (k >= 300) begin mismatches++; stop_test(); end
  endtask
  task automatic get_pkt(input logic [7:0] b, input logic last);
    await(0, 0);
    check({pkt_l, pkt_d}, {last, b});
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 0;
    repeat (n) begin @(negedge clk); seen |= pkt_v | drop; end
    check(seen, 0);
  endtask
  task automatic t_pack;
    send(8'hA5); get_pkt(8'hA5, 1);
    @(posedge clk); to <= 32'h0000_1000; maxp <= 8'h03;
    send(8'h01); send(8'h02); send(8'h03);
    get_pkt(8'h01, 0); get_pkt(8'h02, 0); get_pkt(8'h03, 1);
    @(posedge clk); to <= 32'h0000_0014; maxp <= 8'h08;
    send(8'h21); send(8'h22); quiet(15);
    get_pkt(8'h21, 0); get_pkt(8'h22, 1);
    $display("packet tests done");
  endtask
  task automatic t_cmd;
    @(posedge clk); to <= 32'h0000_1000;
    send(8'h31); repeat (60) @(posedge clk);
    repeat (3) send(8'h2B);
    get_pkt(8'h31, 1);
    repeat (60) @(negedge clk); check(cmd_m, 1);
    send(8'h44); quiet(20);
    pulse(2); repeat (3) @(negedge clk); check(cmd_m, 0);
    $display("command tests done");
  endtask
  task automatic t_rf;
    @(posedge clk); rf_d <= 8'h3C; pulse(0); await(1, 1);
    @(posedge clk); spi <= 1'b1; repeat (3) @(negedge clk); check(fr_eff, 1);
    @(posedge clk); first <= 1'b1; rf_d <= 8'h55; pulse(0); await(1, 5);
    @(posedge clk); first <= 1'b0; ok <= 1'b1; pulse(1); await(1, 7);
    @(posedge clk); ok <= 1'b0; pulse(1); await(1, 9);
    for (int i = 0; i < 9; i++) check(i_host.rx_q[i], exp_b[i]);
    $display("host tests done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_pack(); t_cmd(); t_rf();
    stop_test();
  end
endmodule
bind spk_packetizer spk_packetizer_chk i_chk (.i_ref_clk(i_ref_clk), .i_srst(i_srst),
  .i_spi_active(i_spi_active), .i_ser_valid(i_ser_valid), .i_pkt_ready(i_pkt_ready),
  .i_rf_valid(i_rf_valid), .i_rf_data(i_rf_data), .i_host_ready(i_host_ready),
  .i_max_payload(i_max_payload), .o_pkt_valid(o_pkt_valid), .o_pkt_data(o_pkt_data),
  .o_pkt_last(o_pkt_last), .o_host_valid(o_host_valid), .o_host_data(o_host_data),
  .o_cmd_mode(o_cmd_mode), .o_framed_eff(o_framed_eff), .o_ser_drop(o_ser_drop));
`default_nettype wire
